// ===== rtl/tlic_arbiter.v
// Two-level priority arbiter for the interrupt controller.
`timescale 1ns/1ps
module tlic_arbiter (
	// Requests and levels
	input  wire [23:0] req_i,
	input  wire [23:0] prio_i,
	// Current service level
	input  wire        in_low_i,
	input  wire        in_high_i,
	// Winner
	output reg         valid_o,
	output reg  [4:0]  pos_o,
	output reg         high_o
);

// ----------------------------------------
// Lowest set position wins
// ----------------------------------------
function [4:0] first_idx;
	input [23:0] v;
	integer k;
	begin
		first_idx = 5'h00;
		for (k = 23; k >= 0; k = k - 1) begin
			if (v[k]) begin
				first_idx = k[4:0];
			end
		end
	end
endfunction

wire [23:0] hi_req = req_i & prio_i;
wire [23:0] lo_req = req_i & ~prio_i;
wire        hi_ok  = (|hi_req) & ~in_high_i;
wire        lo_ok  = (|lo_req) & ~in_high_i & ~in_low_i;

// ----------------------------------------
// Selection
// ----------------------------------------
always @* begin
	valid_o = 1'b0;
	pos_o   = 5'h00;
	high_o  = 1'b0;
	if (hi_ok) begin
		valid_o = 1'b1;
		pos_o   = first_idx(hi_req);
		high_o  = 1'b1;
	end else if (lo_ok) begin
		valid_o = 1'b1;
		pos_o   = first_idx(lo_req);
	end
end

endmodule

// ===== rtl/tlic_defines.vh
// Constants for the two-level interrupt controller.
// How it works
// - Every source owns a pending flag set by events.
// - Flags set whether or not enabled.
// - Enabled pending flag requests a call to vector.
// - Return resumes program and ends service level.
// - Disabled pending flag raises no request.
// - Per-source enable bits in three enable registers.
// - Individual enables act only with global enable.
// - Global enable low blocks every source.
// - Clearing enable, single-cycle next: may still call.
// - Clearing enable, multi-cycle next: no call.
// - Some flags cleared on vectoring, rest by software.
// - Flag still set after return requests again.
// - Many sources, each one of two levels.
// - High preempts low; high never preempted.
// - Higher level first, then fixed source order.
// - Requests sampled and decoded every clock.
// - Fastest response one detect cycle plus call.
`ifndef TLIC_DEFINES_VH
`define TLIC_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TLIC_OFF_PRI_EN    4'h0
`define TLIC_OFF_EXT_EN1   4'h1
`define TLIC_OFF_EXT_EN2   4'h2
`define TLIC_OFF_PRIO0     4'h3
`define TLIC_OFF_PRIO1     4'h4
`define TLIC_OFF_PRIO2     4'h5
`define TLIC_OFF_PEND0     4'h6
`define TLIC_OFF_PEND1     4'h7
`define TLIC_OFF_PEND2     4'h8
`define TLIC_OFF_LEVEL     4'h9
`define TLIC_OFF_ISTAT     4'ha
`define TLIC_OFF_IMASK     4'hb
`define TLIC_OFF_CUR       4'hc

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define TLIC_GLOBAL_BIT    7
`define TLIC_RST_BYTE      8'h00
`define TLIC_VALID_POS     24'hffff7f
`define TLIC_AUTOCLR_DEF   24'h000005
`define TLIC_EXT0_POS      0
`define TLIC_EXT1_POS      2
`define TLIC_EV_CALL       0
`define TLIC_EV_REENTER    1
`define TLIC_EV_BLOCKED    2

// ----------------------------------------
// Vector layout and timing
// ----------------------------------------
`define TLIC_VEC_BASE      16'h0003
`define TLIC_VEC_SHIFT     3
`define TLIC_DETECT_CYC    1
`define TLIC_CALL_CYC      5

`endif

// ===== rtl/tlic_top.v
// Top of the two-level interrupt controller with register port and core handshake.
`timescale 1ns/1ps
`include "tlic_defines.vh"
module tlic_top #(
	parameter [23:0] AUTOCLR = `TLIC_AUTOCLR_DEF
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rstn_i,
	// Register port
	input  wire [3:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	input  wire        reg_we_i,
	input  wire        reg_re_i,
	output reg  [7:0]  reg_rdata_o,
	// Interrupt sources
	input  wire [23:0] src_event_i,
	input  wire [1:0]  ext_pin_i,
	// Processor core handshake
	input  wire        core_instr_done_i,
	input  wire        core_next_multi_i,
	input  wire        core_return_from_interrupt_instr_i,
	output reg         irq_req_o,
	output reg         irq_call_o,
	output reg  [15:0] irq_vector_o,
	output reg         irq_high_o,
	// Interrupt to the system
	output reg         irq_o
);

// ----------------------------------------
// State
// ----------------------------------------
reg  [7:0]  primary_int_enable_reg;
reg  [7:0]  extended_enable_reg_one;
reg  [7:0]  extended_enable_reg_two;
reg  [7:0]  primary_priority_reg;
reg  [7:0]  ext_prio_one_reg;
reg  [7:0]  ext_prio_two_reg;
reg  [23:0] pend_reg;
reg  [23:0] pend_next;
reg         in_low_reg;
reg         in_high_reg;
reg         dec_valid_reg;
reg  [4:0]  dec_pos_reg;
reg         dec_high_reg;
reg         dis_reg;
reg         snap_valid_reg;
reg  [4:0]  snap_pos_reg;
reg         snap_high_reg;
reg  [4:0]  cur_pos_reg;
reg  [2:0]  istat_reg;
reg  [2:0]  istat_next;
reg  [2:0]  imask_reg;
reg  [1:0]  ext_s1_reg;
reg  [1:0]  ext_s2_reg;
reg  [1:0]  ext_s3_reg;

// ----------------------------------------
// Helpers
// ----------------------------------------
function [4:0] pos_order;
	input [4:0] pos;
	begin
		if (pos > 5'd7) begin
			pos_order = pos - 5'd1;
		end else begin
			pos_order = pos;
		end
	end
endfunction

function [15:0] vec_addr;
	input [4:0] pos;
	begin
		vec_addr = `TLIC_VEC_BASE + ({11'h000, pos_order(pos)} << `TLIC_VEC_SHIFT);
	end
endfunction

// ----------------------------------------
// Address decoding
// ----------------------------------------
reg sel_en0;
reg sel_en1;
reg sel_en2;
reg sel_pr0;
reg sel_pr1;
reg sel_pr2;
reg sel_pd0;
reg sel_pd1;
reg sel_pd2;
reg sel_ist;
reg sel_imk;

always @* begin
	sel_en0 = 1'b0;
	sel_en1 = 1'b0;
	sel_en2 = 1'b0;
	sel_pr0 = 1'b0;
	sel_pr1 = 1'b0;
	sel_pr2 = 1'b0;
	sel_pd0 = 1'b0;
	sel_pd1 = 1'b0;
	sel_pd2 = 1'b0;
	sel_ist = 1'b0;
	sel_imk = 1'b0;
	if (reg_addr_i == `TLIC_OFF_PRI_EN) begin
		sel_en0 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_EXT_EN1) begin
		sel_en1 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_EXT_EN2) begin
		sel_en2 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_PRIO0) begin
		sel_pr0 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_PRIO1) begin
		sel_pr1 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_PRIO2) begin
		sel_pr2 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_PEND0) begin
		sel_pd0 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_PEND1) begin
		sel_pd1 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_PEND2) begin
		sel_pd2 = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_ISTAT) begin
		sel_ist = 1'b1;
	end else if (reg_addr_i == `TLIC_OFF_IMASK) begin
		sel_imk = 1'b1;
	end
end

wire wr_en0 = reg_we_i & sel_en0;
wire wr_en1 = reg_we_i & sel_en1;
wire wr_en2 = reg_we_i & sel_en2;
wire wr_pd0 = reg_we_i & sel_pd0;
wire wr_pd1 = reg_we_i & sel_pd1;
wire wr_pd2 = reg_we_i & sel_pd2;

// ----------------------------------------
// External pin synchronisers
// ----------------------------------------
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		ext_s1_reg <= 2'h0;
		ext_s2_reg <= 2'h0;
		ext_s3_reg <= 2'h0;
	end else begin
		ext_s1_reg <= ext_pin_i;
		ext_s2_reg <= ext_s1_reg;
		ext_s3_reg <= ext_s2_reg;
	end
end

wire [1:0]  ext_rise = ext_s2_reg & ~ext_s3_reg;
wire [23:0] ext_vec  = ({23'h000000, ext_rise[0]} << `TLIC_EXT0_POS) |
                       ({23'h000000, ext_rise[1]} << `TLIC_EXT1_POS);
wire [23:0] ev_vec   = (src_event_i | ext_vec) & `TLIC_VALID_POS;

// ----------------------------------------
// Request qualification and arbitration
// ----------------------------------------
wire        global_int_enable = primary_int_enable_reg[`TLIC_GLOBAL_BIT];
wire [23:0] en_vec   = {extended_enable_reg_two, extended_enable_reg_one,
                        primary_int_enable_reg} & `TLIC_VALID_POS;
wire [23:0] prio_vec = {ext_prio_two_reg, ext_prio_one_reg,
                        primary_priority_reg} & `TLIC_VALID_POS;
wire [23:0] req_vec  = pend_reg & en_vec & {24{global_int_enable}};
wire        arb_valid;
wire [4:0]  arb_pos;
wire        arb_high;

tlic_arbiter u_arb (
	.req_i     (req_vec),
	.prio_i    (prio_vec),
	.in_low_i  (in_low_reg),
	.in_high_i (in_high_reg),
	.valid_o   (arb_valid),
	.pos_o     (arb_pos),
	.high_o    (arb_high)
);

wire       use_valid = dis_reg ? (snap_valid_reg & ~core_next_multi_i) : dec_valid_reg;
wire [4:0] use_pos   = dis_reg ? snap_pos_reg : dec_pos_reg;
wire       use_high  = dis_reg ? snap_high_reg : dec_high_reg;
wire       call_fire = core_instr_done_i & use_valid;

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		dec_valid_reg <= 1'b0;
		dec_pos_reg   <= 5'h00;
		dec_high_reg  <= 1'b0;
	end else begin
		dec_valid_reg <= arb_valid & ~call_fire;
		dec_pos_reg   <= arb_pos;
		dec_high_reg  <= arb_high;
	end
end

// ----------------------------------------
// Enable-clear window
// ----------------------------------------
wire clr_any = (wr_en0 & (|(primary_int_enable_reg & ~reg_wdata_i))) |
               (wr_en1 & (|(extended_enable_reg_one & ~reg_wdata_i))) |
               (wr_en2 & (|(extended_enable_reg_two & ~reg_wdata_i)));

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		dis_reg        <= 1'b0;
		snap_valid_reg <= 1'b0;
		snap_pos_reg   <= 5'h00;
		snap_high_reg  <= 1'b0;
	end else if (clr_any) begin
		dis_reg        <= 1'b1;
		snap_valid_reg <= arb_valid & ~call_fire;
		snap_pos_reg   <= arb_pos;
		snap_high_reg  <= arb_high;
	end else if (core_instr_done_i) begin
		dis_reg        <= 1'b0;
		snap_valid_reg <= 1'b0;
	end
end

// ----------------------------------------
// Pending flags
// ----------------------------------------
wire [23:0] auto_hit = call_fire ? (AUTOCLR & (24'h000001 << use_pos)) : 24'h000000;

always @* begin
	pend_next = pend_reg;
	if (wr_pd0) begin
		pend_next[7:0] = reg_wdata_i;
	end
	if (wr_pd1) begin
		pend_next[15:8] = reg_wdata_i;
	end
	if (wr_pd2) begin
		pend_next[23:16] = reg_wdata_i;
	end
	pend_next = ((pend_next & ~auto_hit) | ev_vec) & `TLIC_VALID_POS;
end

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		pend_reg <= 24'h000000;
	end else begin
		pend_reg <= pend_next;
	end
end

// ----------------------------------------
// Enable and priority registers
// ----------------------------------------
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		primary_int_enable_reg  <= `TLIC_RST_BYTE;
		extended_enable_reg_one <= `TLIC_RST_BYTE;
		extended_enable_reg_two <= `TLIC_RST_BYTE;
		primary_priority_reg    <= `TLIC_RST_BYTE;
		ext_prio_one_reg        <= `TLIC_RST_BYTE;
		ext_prio_two_reg        <= `TLIC_RST_BYTE;
	end else if (reg_we_i) begin
		if (sel_en0) begin
			primary_int_enable_reg <= reg_wdata_i;
		end
		if (sel_en1) begin
			extended_enable_reg_one <= reg_wdata_i;
		end
		if (sel_en2) begin
			extended_enable_reg_two <= reg_wdata_i;
		end
		if (sel_pr0) begin
			primary_priority_reg <= reg_wdata_i & 8'h7f;
		end
		if (sel_pr1) begin
			ext_prio_one_reg <= reg_wdata_i;
		end
		if (sel_pr2) begin
			ext_prio_two_reg <= reg_wdata_i;
		end
	end
end

// ----------------------------------------
// Service levels
// ----------------------------------------
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		in_low_reg  <= 1'b0;
		in_high_reg <= 1'b0;
	end else if (call_fire) begin
		if (use_high) begin
			in_high_reg <= 1'b1;
		end else begin
			in_low_reg <= 1'b1;
		end
	end else if (core_return_from_interrupt_instr_i) begin
		if (in_high_reg) begin
			in_high_reg <= 1'b0;
		end else begin
			in_low_reg <= 1'b0;
		end
	end
end

// ----------------------------------------
// Core outputs
// ----------------------------------------
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		irq_req_o    <= 1'b0;
		irq_call_o   <= 1'b0;
		irq_vector_o <= `TLIC_VEC_BASE;
		irq_high_o   <= 1'b0;
		cur_pos_reg  <= 5'h00;
	end else begin
		irq_req_o  <= arb_valid & ~call_fire;
		irq_call_o <= call_fire;
		if (call_fire) begin
			irq_vector_o <= vec_addr(use_pos);
			irq_high_o   <= use_high;
			cur_pos_reg  <= use_pos;
		end
	end
end

// ----------------------------------------
// Event status, mask and interrupt line
// ----------------------------------------
wire [2:0] ev_bits;
assign ev_bits[`TLIC_EV_CALL]    = call_fire;
assign ev_bits[`TLIC_EV_REENTER] = core_return_from_interrupt_instr_i & (|req_vec);
assign ev_bits[`TLIC_EV_BLOCKED] = |(ev_vec & ~(en_vec & {24{global_int_enable}}));

always @* begin
	istat_next = istat_reg;
	if (reg_we_i & sel_ist) begin
		istat_next = istat_next & ~reg_wdata_i[2:0];
	end
	istat_next = istat_next | ev_bits;
end

always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		istat_reg <= 3'h0;
		imask_reg <= 3'h0;
		irq_o     <= 1'b0;
	end else begin
		istat_reg <= istat_next;
		if (reg_we_i & sel_imk) begin
			imask_reg <= reg_wdata_i[2:0];
		end
		irq_o <= |(istat_next & ((reg_we_i & sel_imk) ? reg_wdata_i[2:0] : imask_reg));
	end
end

// ----------------------------------------
// Read port
// ----------------------------------------
always @(posedge clk_i or negedge rstn_i) begin
	if (!rstn_i) begin
		reg_rdata_o <= 8'h00;
	end else if (!reg_re_i) begin
		reg_rdata_o <= 8'h00;
	end else if (reg_addr_i == `TLIC_OFF_PRI_EN) begin
		reg_rdata_o <= primary_int_enable_reg;
	end else if (reg_addr_i == `TLIC_OFF_EXT_EN1) begin
		reg_rdata_o <= extended_enable_reg_one;
	end else if (reg_addr_i == `TLIC_OFF_EXT_EN2) begin
		reg_rdata_o <= extended_enable_reg_two;
	end else if (reg_addr_i == `TLIC_OFF_PRIO0) begin
		reg_rdata_o <= primary_priority_reg;
	end else if (reg_addr_i == `TLIC_OFF_PRIO1) begin
		reg_rdata_o <= ext_prio_one_reg;
	end else if (reg_addr_i == `TLIC_OFF_PRIO2) begin
		reg_rdata_o <= ext_prio_two_reg;
	end else if (reg_addr_i == `TLIC_OFF_PEND0) begin
		reg_rdata_o <= pend_reg[7:0];
	end else if (reg_addr_i == `TLIC_OFF_PEND1) begin
		reg_rdata_o <= pend_reg[15:8];
	end else if (reg_addr_i == `TLIC_OFF_PEND2) begin
		reg_rdata_o <= pend_reg[23:16];
	end else if (reg_addr_i == `TLIC_OFF_LEVEL) begin
		reg_rdata_o <= {5'h00, dec_valid_reg, in_high_reg, in_low_reg};
	end else if (reg_addr_i == `TLIC_OFF_ISTAT) begin
		reg_rdata_o <= {5'h00, istat_reg};
	end else if (reg_addr_i == `TLIC_OFF_IMASK) begin
		reg_rdata_o <= {5'h00, imask_reg};
	end else if (reg_addr_i == `TLIC_OFF_CUR) begin
		reg_rdata_o <= {3'h0, pos_order(cur_pos_reg)};
	end else begin
		reg_rdata_o <= 8'h00;
	end
end

endmodule

// ===== tb/tb_two_level_interrupt_controller.sv
// Self-checking testbench of the two-level interrupt controller.
`timescale 1ns/1ps
module tb_two_level_interrupt_controller;
	reg         clk_i = 1'h0;
	reg         rstn_i;
	reg  [3:0]  reg_addr_i;
	reg  [7:0]  reg_wdata_i;
	reg         reg_we_i;
	reg         reg_re_i;
	reg  [23:0] src_event_i;
	reg  [1:0]  ext_pin_i;
	reg         slow;
	reg         multi;
	reg         ret;
	reg         rd_pend = 1'h0;
	reg  [31:0] lfsr = 32'h41c6;
	reg  [7:0]  r;
	reg  [7:0]  rq[$];
	reg  [16:0] vq[$];
	wire [7:0]  reg_rdata_o;
	wire [15:0] irq_vector_o;
	wire        done, nmulti, return_from_interrupt_instr, irq_req_o, irq_call_o, irq_high_o, irq_o;
	integer     bad_count = 0;
	integer     samples_checked = 0;
	integer     i;
	always #12.5 clk_i = ~clk_i;
	tlic_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
		.src_event_i(src_event_i), .ext_pin_i(ext_pin_i), .core_instr_done_i(done),
		.core_next_multi_i(nmulti), .core_return_from_interrupt_instr_i(return_from_interrupt_instr), .irq_req_o(irq_req_o), .irq_call_o(irq_call_o),
		.irq_vector_o(irq_vector_o), .irq_high_o(irq_high_o), .irq_o(irq_o));
	tlic_core_model core (.clk_i(clk_i), .rstn_i(rstn_i), .slow_i(slow), .multi_i(multi), .ret_i(ret),
		.call_i(irq_call_o), .done_o(done), .multi_o(nmulti), .return_from_interrupt_instr_o(return_from_interrupt_instr));
	// --------------------------------
	// Tasks
	// --------------------------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			reg_addr_i <= a;
			reg_wdata_i <= d;
			reg_we_i <= 1'h1;
			cyc(1);
			reg_we_i <= 1'h0;
			cyc(1);
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			rq.push_back(e);
			reg_addr_i <= a;
			reg_re_i <= 1'h1;
			cyc(1);
			reg_re_i <= 1'h0;
			cyc(1);
		end
	endtask
	task ev(input [23:0] m);
		begin
			src_event_i <= m;
			cyc(1);
			src_event_i <= 24'h000000;
			cyc(1);
		end
	endtask
	task rti;
		begin
			ret <= 1'h1;
			cyc(1);
			ret <= 1'h0;
			cyc(1);
		end
	endtask
	task flush;
		begin
			cyc(20);
			chk(vq.size(), 0);
		end
	endtask
	task print_verdict;
		begin
			if (bad_count == 0 && samples_checked > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// --------------------------------
	// Result watcher and scenarios
	// --------------------------------
	always @(posedge clk_i) begin
		rd_pend <= reg_re_i;
		if (rd_pend)
			chk(reg_rdata_o, rq.pop_front());
		if (irq_call_o && vq.size() == 0)
			chk(1, 0);
		else if (irq_call_o)
			chk({irq_high_o, irq_vector_o}, vq.pop_front());
	end
	initial begin
		cyc(5000);
		bad_count = bad_count + 1;
		print_verdict;
	end
	initial begin
		rstn_i <= 1'h0;
		reg_addr_i <= 4'h0;
		reg_wdata_i <= 8'h00;
		reg_we_i <= 1'h0;
		reg_re_i <= 1'h0;
		src_event_i <= 24'h000000;
		ext_pin_i <= 2'h0;
		slow <= 1'h0;
		multi <= 1'h0;
		ret <= 1'h0;
		cyc(4);
		rstn_i <= 1'h1;
		cyc(1);
		for (i = 0; i < 16; i = i + 1)
			rd(i[3:0], 8'h00);
		for (i = 1; i < 6; i = i + 1) begin
			if (i != 3) begin
				lfsr = nx(lfsr);
				r = lfsr[7:0];
				wr(i[3:0], r);
				rd(i[3:0], r);
				wr(i[3:0], 8'h00);
			end
		end
		wr(4'h0, 8'h02);
		ev(24'h000002);
		cyc(10);
		rd(4'h6, 8'h02);
		vq.push_back(17'h0000b);
		wr(4'h0, 8'h82);
		flush;
		rd(4'h6, 8'h02);
		vq.push_back(17'h0000b);
		rti;
		flush;
		wr(4'h6, 8'h00);
		rti;
		wr(4'h0, 8'h85);
		vq.push_back(17'h00003);
		ext_pin_i <= 2'h3;
		flush;
		rd(4'h6, 8'h04);
		vq.push_back(17'h00013);
		rti;
		flush;
		rd(4'h6, 8'h00);
		rti;
		wr(4'h3, 8'h10);
		wr(4'h0, 8'h98);
		vq.push_back(17'h10023);
		ev(24'h000018);
		flush;
		wr(4'h6, 8'h08);
		vq.push_back(17'h0001b);
		rti;
		flush;
		vq.push_back(17'h10023);
		ev(24'h000010);
		flush;
		wr(4'h6, 8'h00);
		rti;
		rti;
		wr(4'h3, 8'h00);
		for (i = 0; i < 2; i = i + 1) begin
			slow <= 1'h1;
			multi <= (i == 0);
			wr(4'h0, 8'ha0);
			ev(24'h000020);
			cyc(3);
			wr(4'h0, 8'h80);
			if (i == 1)
				vq.push_back(17'h0002b);
			slow <= 1'h0;
			flush;
			rd(4'h0, 8'h80);
			wr(4'h6, 8'h00);
			if (i == 1)
				rti;
		end
		wr(4'hb, 8'h00);
		wr(4'ha, 8'h07);
		rd(4'ha, 8'h00);
		wr(4'h0, 8'h82);
		vq.push_back(17'h0000b);
		ev(24'h000002);
		flush;
		rd(4'ha, 8'h01);
		chk(irq_o, 1'h0);
		wr(4'hb, 8'h01);
		chk(irq_o, 1'h1);
		wr(4'ha, 8'h01);
		chk(irq_o, 1'h0);
		wr(4'h6, 8'h00);
		rti;
		wr(4'h0, 8'h02);
		wr(4'h6, 8'h02);
		flush;
		rstn_i <= 1'h0;
		cyc(2);
		rstn_i <= 1'h1;
		cyc(2);
		rd(4'h6, 8'h00);
		cyc(2);
		print_verdict;
	end
endmodule

// ===== tb/tlic_chk_sva.sv
// Assertion checker of the interrupt controller's port behaviour.
`timescale 1ns/1ps
module tlic_chk (
	// Clock and reset
	input logic        clk_i,
	input logic        rstn_i,
	// Register port
	input logic [3:0]  reg_addr_i,
	input logic [7:0]  reg_wdata_i,
	input logic        reg_we_i,
	input logic        reg_re_i,
	input logic [7:0]  reg_rdata_o,
	// Core handshake
	input logic        core_instr_done_i,
	input logic        core_return_from_interrupt_instr_i,
	input logic        irq_req_o,
	input logic        irq_call_o,
	input logic [15:0] irq_vector_o,
	input logic        irq_high_o
);
	reg  ge_reg;
	reg  blk_reg;
	reg  hi_reg;
	reg  lo_reg;
	wire ge_wr = reg_we_i && reg_addr_i == 4'h0;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// --------------------------------
	// Service state seen from the ports
	// --------------------------------
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ge_reg  <= 1'h0;
			blk_reg <= 1'h0;
			hi_reg  <= 1'h0;
			lo_reg  <= 1'h0;
		end else begin
			if (ge_wr)
				ge_reg <= reg_wdata_i[7];
			blk_reg <= !(ge_wr && reg_wdata_i[7]) && !ge_reg && (blk_reg || core_instr_done_i);
			if (irq_call_o && irq_high_o)
				hi_reg <= 1'h1;
			else if (core_return_from_interrupt_instr_i)
				hi_reg <= 1'h0;
			if (irq_call_o && !irq_high_o)
				lo_reg <= 1'h1;
			else if (core_return_from_interrupt_instr_i && !hi_reg)
				lo_reg <= 1'h0;
		end
	end
	// --------------------------------
	// Assertions
	// --------------------------------
	call_cause_a: assert property (irq_call_o |-> $past(core_instr_done_i))
		else $error("call without finished instruction");
	vec_fmt_a: assert property (irq_call_o |-> irq_vector_o[2:0] == 3'h3 && irq_vector_o <= 16'h00b3)
		else $error("bad vector");
	vec_hold_a: assert property (!irq_call_o |-> $stable(irq_vector_o) && $stable(irq_high_o))
		else $error("vector moved without call");
	rd_idle_a: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");
	rd_unmap_a: assert property ($past(reg_re_i) && $past(reg_addr_i) > 4'hc |-> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	ge_block_a: assert property (blk_reg |=> !irq_call_o)
		else $error("call with global enable off");
	req_gate_a: assert property (blk_reg && $past(blk_reg) |-> !irq_req_o)
		else $error("request with global enable off");
	nest_rule_a: assert property (irq_call_o && (hi_reg || lo_reg) |-> irq_high_o && !hi_reg)
		else $error("illegal nesting");
	cover property (irq_call_o && irq_high_o);
	cover property (irq_call_o && lo_reg);
	cover property (core_return_from_interrupt_instr_i && irq_req_o);
endmodule

bind tlic_top tlic_chk u_chk (.clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
	.reg_rdata_o, .core_instr_done_i, .core_return_from_interrupt_instr_i, .irq_req_o, .irq_call_o, .irq_vector_o, .irq_high_o);

// ===== tb/tlic_core_model.sv
// Behavioural processor core answering the controller's handshake.
`timescale 1ns/1ps
module tlic_core_model (
	// Clock and reset
	input  wire clk_i,
	input  wire rstn_i,
	// Bench controls
	input  wire slow_i,
	input  wire multi_i,
	input  wire ret_i,
	// Controller side
	input  wire call_i,
	output reg  done_o,
	output reg  multi_o,
	output reg  return_from_interrupt_instr_o
);
	reg [2:0] busy_reg;
	reg [3:0] depth_reg;
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			done_o    <= 1'h0;
			multi_o   <= 1'h0;
			return_from_interrupt_instr_o    <= 1'h0;
			busy_reg  <= 3'h0;
			depth_reg <= 4'h0;
		end else begin
			done_o  <= 1'h0;
			return_from_interrupt_instr_o  <= 1'h0;
			multi_o <= multi_i;
			if (call_i) begin
				busy_reg  <= 3'h5;
				depth_reg <= depth_reg + 4'h1;
			end else if (busy_reg != 3'h0) begin
				busy_reg <= busy_reg - 3'h1;
			end else if (ret_i && depth_reg != 4'h0) begin
				return_from_interrupt_instr_o    <= 1'h1;
				depth_reg <= depth_reg - 4'h1;
			end else if (!slow_i) begin
				done_o <= 1'h1;
			end
		end
	end
endmodule
